// ### design/pdw_pkg.sv
// package for the power-down / wake-up / low-voltage detect block
// assumes a 32-bit apb slave on pclk; all constants used by more than one file live here
package pdw_pkg;
  // register byte addresses (no offsets printed, chosen here)
  localparam logic [7:0] ADDR_LVD_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_WAKE_EN = 8'h08;
  localparam logic [7:0] ADDR_IRQ = 8'h0c;
  localparam logic [7:0] ADDR_WAKE_CAUSE = 8'h10;
  // low_voltage_detect_ctrl field layout
  localparam int LVD_OUT_BIT = 5;
  localparam int LVD_ON_BIT = 4;
  localparam int LVD_THR_LSB = 0;
  localparam int LVD_THR_W = 3;
  localparam logic [7:0] LVD_CTRL_RESET = 8'h00;
  // status bits
  localparam int ST_PD_BIT = 0;
  localparam int ST_TO_BIT = 1;
  localparam int ST_SLEEP_BIT = 2;
  // wake cause codes
  localparam logic [2:0] CAUSE_NONE = 3'h0;
  localparam logic [2:0] CAUSE_EXT_RESET = 3'h1;
  localparam logic [2:0] CAUSE_PORTA = 3'h2;
  localparam logic [2:0] CAUSE_IRQ = 3'h3;
  localparam logic [2:0] CAUSE_WDT = 3'h4;
  // timing
  localparam int CLK_MHZ = 50;
  localparam int IRQ_DELAY_US = 1;
  localparam int IRQ_DELAY_CYC = IRQ_DELAY_US * CLK_MHZ;
  localparam int CLK_RESTART_NS = 200;
  localparam int CLK_RESTART_CYC = (CLK_RESTART_NS * CLK_MHZ + 999) / 1000;
  typedef enum logic [1:0]
  {
    PDW_RUN = 2'b00,
    PDW_SLEEP = 2'b01,
    PDW_RESTART = 2'b10,
    PDW_RESUME = 2'b11
  } pdw_state_type;
endpackage : pdw_pkg

// ### design/pdw_sync.sv
// two-flop synchroniser for a bundle of asynchronous levels
// assumes the inputs come from pins outside the pclk domain
`timescale 1ns/1ps
module pdw_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // clocking
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      // reset to each pin's idle level so no false edge follows reset
      stage1 <= RESET_VAL;
      sync_out <= RESET_VAL;
    end
    else if (clk_en)
    begin
      stage1 <= async_in;
      sync_out <= stage1;
    end
  end
endmodule : pdw_sync

// ### design/pdw_lvd_delay.sv
// qualifies the low-voltage comparator output: flag only after a fixed delay
// assumes low_in is already synchronised to pclk
`timescale 1ns/1ps
module pdw_lvd_delay
  import pdw_pkg::*;
#(
  parameter int DELAY_CYC = IRQ_DELAY_CYC
) (
  // clocking
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // detector
  input wire logic low_in,
  output logic fire
);
  logic [15:0] count;

  // fire pulses once when low has held for the full delay; a dip restarts the wait
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count <= '0;
      fire <= 1'b0;
    end
    else if (clk_en)
    begin
      fire <= 1'b0;
      if (!low_in)
        count <= '0;
      else if (count < 16'(DELAY_CYC))
      begin
        count <= count + 16'h0001;
        fire <= (count == 16'(DELAY_CYC - 1));
      end
    end
  end

  AST_DELAY_NOT_EARLY: assert property (@(posedge pclk) disable iff (!presetn)
    fire |-> (count == 16'(DELAY_CYC)))
    else $error("detector fired without low voltage");
endmodule : pdw_lvd_delay

// ### design/pdw_power_down_wakeup_lvd.sv
// power-down entry, wake-up sources and low-voltage detector register
// assumes: core gives one-cycle halt/wdt-clear strobes; pins and analog comparator
// are asynchronous; pclk itself keeps running (the gated system clock is an output)
`timescale 1ns/1ps
module pdw_power_down_wakeup_lvd
  import pdw_pkg::*;
#(
  parameter int PORTA_W = 8,
  parameter int IRQ_W = 8,
  parameter int RESTART_CYC = CLK_RESTART_CYC,
  parameter int LVD_DELAY_CYC = IRQ_DELAY_CYC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // processor core
  input wire logic halt_strobe,
  input wire logic wdt_clear_strobe,
  input wire logic stack_full,
  input wire logic [IRQ_W-1:0] irq_flags,
  input wire logic [IRQ_W-1:0] irq_enables,
  output logic sys_clk_en,
  output logic core_hold,
  output logic state_retain,
  output logic resume_after_halt,
  output logic vector_irq,
  output logic pending_irq,
  output logic full_reset,
  output logic wdt_reset,
  output logic low_voltage_irq_flag,
  // watchdog
  input wire logic wdt_enabled,
  input wire logic wdt_from_sub_clk,
  input wire logic wdt_overflow,
  output logic wdt_counter_clear,
  output logic wdt_run,
  // pins and analog
  input wire logic ext_reset_req_n,
  input wire logic [PORTA_W-1:0] porta_pins,
  input wire logic lvd_comparator_low,
  output logic detector_on,
  output logic [LVD_THR_W-1:0] threshold_select
);
  pdw_state_type state;
  pdw_state_type next_state;
  logic power_down_flag;
  logic watchdog_timeout_flag;
  logic [PORTA_W-1:0] porta_wake_enables;
  logic [PORTA_W-1:0] porta_s;
  logic [PORTA_W-1:0] porta_prev;
  logic [IRQ_W-1:0] irq_prev;
  logic ext_reset_n_s;
  logic low_voltage_output;
  logic lvd_fire;
  logic [2:0] cause;
  logic [2:0] next_cause;
  logic [15:0] restart_cnt;
  logic [IRQ_W-1:0] wake_irq_vec;
  logic irq_rise;
  logic porta_fall;
  logic wake_any;
  logic sleeping;
  logic apb_wr;
  logic apb_rd;
  logic lvd_flag_clear;

  // one address decode shared by read and write paths
  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] target);
    addr_is = (a == target);
  endfunction : addr_is

  pdw_sync #(.WIDTH(PORTA_W + 2), .RESET_VAL({{PORTA_W{1'b1}}, 2'b10})) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .async_in({porta_pins, ext_reset_req_n, lvd_comparator_low}),
    .sync_out({porta_s, ext_reset_n_s, low_voltage_output})
  );

  pdw_lvd_delay #(.DELAY_CYC(LVD_DELAY_CYC)) u_delay (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .low_in(low_voltage_output & detector_on),
    .fire(lvd_fire)
  );

  assign sleeping = (state == PDW_SLEEP);
  assign apb_wr = psel & penable & pwrite;
  assign apb_rd = psel & penable & ~pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  // only a rising flag or falling enabled pin counts, so a flag high at entry cannot wake
  assign irq_rise = |(irq_flags & ~irq_prev);
  assign porta_fall = |(porta_prev & ~porta_s & porta_wake_enables);
  assign wake_any = ~ext_reset_n_s | porta_fall | irq_rise
    | (wdt_overflow & wdt_run) | lvd_fire;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      porta_prev <= '1;
      irq_prev <= '0;
    end
    else if (clk_en)
    begin
      porta_prev <= porta_s;
      irq_prev <= irq_flags;
    end
  end

  always_comb
  begin
    next_state = state;
    next_cause = cause;
    case (state)
      PDW_RUN:
        if (halt_strobe)
        begin
          next_state = PDW_SLEEP;
          next_cause = CAUSE_NONE;
        end
      PDW_SLEEP:
        if (wake_any)
        begin
          next_state = PDW_RESTART;
          if (!ext_reset_n_s)
            next_cause = CAUSE_EXT_RESET;
          else if (wdt_overflow & wdt_run)
            next_cause = CAUSE_WDT;
          else if (porta_fall)
            next_cause = CAUSE_PORTA;
          else
            next_cause = CAUSE_IRQ;
        end
      PDW_RESTART:
        if (restart_cnt >= 16'(RESTART_CYC))
          next_state = PDW_RESUME;
      PDW_RESUME:
        next_state = PDW_RUN;
      default:
        next_state = PDW_RUN;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= PDW_RUN;
      cause <= CAUSE_NONE;
    end
    else if (clk_en)
    begin
      state <= next_state;
      cause <= next_cause;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      restart_cnt <= '0;
    else if (clk_en)
    begin
      if (state == PDW_RESTART)
        restart_cnt <= restart_cnt + 16'h0001;
      else
        restart_cnt <= '0;
    end
  end

  // clock comes back from the third restart cycle, before the restart wait has elapsed; nothing resumes before the wait ends
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sys_clk_en <= 1'b1;
      core_hold <= 1'b0;
      state_retain <= 1'b0;
    end
    else if (clk_en)
    begin
      sys_clk_en <= (next_state == PDW_RUN) || (next_state == PDW_RESUME)
        || (next_state == PDW_RESTART && restart_cnt != 16'h0000);
      core_hold <= (next_state != PDW_RUN);
      state_retain <= (next_state == PDW_SLEEP) || (next_state == PDW_RESTART);
    end
  end

  // wake actions fire as one-cycle pulses on the resume step
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      full_reset <= 1'b0;
      wdt_reset <= 1'b0;
      resume_after_halt <= 1'b0;
      vector_irq <= 1'b0;
      wake_irq_vec <= '0;
    end
    else if (clk_en)
    begin
      full_reset <= 1'b0;
      wdt_reset <= 1'b0;
      resume_after_halt <= 1'b0;
      vector_irq <= 1'b0;
      // forget the last wake's flags on entry, so a pin or detector wake cannot vector on them
      if (state == PDW_RUN && halt_strobe)
        wake_irq_vec <= '0;
      else if (state == PDW_SLEEP && irq_rise)
        wake_irq_vec <= irq_flags & ~irq_prev;
      if (state == PDW_RESUME)
      begin
        case (cause)
          CAUSE_EXT_RESET: full_reset <= 1'b1;
          CAUSE_WDT: wdt_reset <= 1'b1;
          CAUSE_PORTA: resume_after_halt <= 1'b1;
          CAUSE_IRQ:
            if ((|(wake_irq_vec & irq_enables)) && !stack_full)
              vector_irq <= 1'b1;
            else
              resume_after_halt <= 1'b1;
          default: resume_after_halt <= 1'b1;
        endcase
      end
    end
  end

  // in run, pending is high while a request flag is up and none can be serviced (none enabled, or stack full)
  assign pending_irq = (state == PDW_RUN) && (|irq_flags)
    && (!(|(irq_flags & irq_enables)) || stack_full);

  assign wdt_counter_clear = (state == PDW_RUN) && halt_strobe;
  assign wdt_run = wdt_enabled && (!sleeping || wdt_from_sub_clk);

  // status flags; the halt set wins over a same-cycle watchdog clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      power_down_flag <= 1'b0;
      watchdog_timeout_flag <= 1'b0;
    end
    else if (clk_en)
    begin
      if (state == PDW_RUN && halt_strobe)
      begin
        power_down_flag <= 1'b1;
        watchdog_timeout_flag <= 1'b0;
      end
      else
      begin
        if (wdt_clear_strobe)
          power_down_flag <= 1'b0;
        if (next_cause == CAUSE_WDT && state == PDW_SLEEP)
          watchdog_timeout_flag <= 1'b1;
        else if (wdt_clear_strobe)
          watchdog_timeout_flag <= 1'b0;
      end
    end
  end

  // software-written configuration
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      detector_on <= LVD_CTRL_RESET[LVD_ON_BIT];
      threshold_select <= LVD_CTRL_RESET[LVD_THR_LSB +: LVD_THR_W];
      porta_wake_enables <= '0;
    end
    else if (clk_en && apb_wr)
    begin
      if (addr_is(paddr, ADDR_LVD_CTRL))
      begin
        detector_on <= pwdata[LVD_ON_BIT];
        threshold_select <= pwdata[LVD_THR_LSB +: LVD_THR_W];
      end
      if (addr_is(paddr, ADDR_WAKE_EN))
        porta_wake_enables <= pwdata[PORTA_W-1:0];
    end
  end

  // detector flag: set wins over a software clear in the same cycle
  assign lvd_flag_clear = clk_en && apb_wr && addr_is(paddr, ADDR_IRQ) && pwdata[0];
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      low_voltage_irq_flag <= 1'b0;
    else if (clk_en)
    begin
      if (lvd_fire)
        low_voltage_irq_flag <= 1'b1;
      else if (lvd_flag_clear)
        low_voltage_irq_flag <= 1'b0;
    end
  end

  // read data registered at the setup phase; unmapped addresses read zero
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= '0;
    else if (clk_en && psel && !penable && !pwrite)
    begin
      prdata <= '0;
      if (addr_is(paddr, ADDR_LVD_CTRL))
      begin
        prdata[LVD_OUT_BIT] <= low_voltage_output & detector_on;
        prdata[LVD_ON_BIT] <= detector_on;
        prdata[LVD_THR_LSB +: LVD_THR_W] <= threshold_select;
      end
      else if (addr_is(paddr, ADDR_STATUS))
      begin
        prdata[ST_PD_BIT] <= power_down_flag;
        prdata[ST_TO_BIT] <= watchdog_timeout_flag;
        prdata[ST_SLEEP_BIT] <= sleeping;
      end
      else if (addr_is(paddr, ADDR_WAKE_EN))
        prdata[PORTA_W-1:0] <= porta_wake_enables;
      else if (addr_is(paddr, ADDR_IRQ))
        prdata[0] <= low_voltage_irq_flag;
      else if (addr_is(paddr, ADDR_WAKE_CAUSE))
        prdata[2:0] <= cause;
    end
  end

  AST_HALT_SLEEPS: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && state == PDW_RUN && halt_strobe) |=> (state == PDW_SLEEP && core_hold))
    else $error("halt did not enter sleep");
  AST_HALT_FLAGS: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && state == PDW_RUN && halt_strobe) |=> (power_down_flag && !watchdog_timeout_flag))
    else $error("halt flags wrong");
  AST_CLK_OFF_ASLEEP: assert property (@(posedge pclk) disable iff (!presetn)
    (state == PDW_SLEEP) |-> (!sys_clk_en && state_retain))
    else $error("clock running while asleep");
  AST_WDT_HALTS: assert property (@(posedge pclk) disable iff (!presetn)
    (sleeping && !wdt_from_sub_clk) |-> !wdt_run)
    else $error("watchdog ran from system clock asleep");
  AST_WAKE_LEAVES: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && sleeping && wake_any) |=> (state == PDW_RESTART))
    else $error("wake event ignored");
  AST_EXT_FULL_RESET: assert property (@(posedge pclk) disable iff (!presetn)
    (state == PDW_RESUME && cause == CAUSE_EXT_RESET && clk_en) |=> full_reset)
    else $error("no full reset on external wake");
  AST_CLK_BEFORE_ACTION: assert property (@(posedge pclk) disable iff (!presetn)
    (resume_after_halt || vector_irq || wdt_reset || full_reset) |-> $past(sys_clk_en))
    else $error("action before clock restart");
  AST_VECTOR_OK: assert property (@(posedge pclk) disable iff (!presetn)
    vector_irq |-> !$past(stack_full))
    else $error("vectored with full stack");
  AST_LVF_SET: assert property (@(posedge pclk) disable iff (!presetn)
    (clk_en && lvd_fire) |=> low_voltage_irq_flag)
    else $error("detector flag not set");
  COV_PORTA_WAKE: cover property (@(posedge pclk) resume_after_halt && cause == CAUSE_PORTA);
  COV_IRQ_VECTOR: cover property (@(posedge pclk) vector_irq);
  COV_WDT_WAKE: cover property (@(posedge pclk) wdt_reset);
  COV_LVD_FLAG: cover property (@(posedge pclk) $rose(low_voltage_irq_flag));
endmodule : pdw_power_down_wakeup_lvd

// ### verification/pdw_core_model.sv
// core-side partner: turns a bench halt request into the single-cycle halt strobe
// assumes the block's sys_clk_en and core_hold outputs share pclk with it
`timescale 1ns/1ps
module pdw_core_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // block status
  input wire logic sys_clk_en,
  input wire logic core_hold,
  // bench request
  input wire logic halt_req,
  output logic halt_strobe
);
  // a stalled or unclocked core cannot execute a halt, so such requests are dropped
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      halt_strobe <= 1'b0;
    else
      halt_strobe <= halt_req & sys_clk_en & ~core_hold & ~halt_strobe;
  end
endmodule : pdw_core_model

// ### verification/tb.sv
// self-checking bench for the power-down, wake-up and low-voltage block
// assumes pdw_pkg and the core model; restart and detector delays shortened
`timescale 1ns/1ps
module tb;
  import pdw_pkg::*;
  localparam int RST_C = 2;
  localparam int DLY_C = 4;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, halt_strobe;
  logic halt_req = 1'b0;
  logic clk_en = 1'b1;
  logic wdt_clear_strobe = 1'b0;
  logic stack_full = 1'b0;
  logic [7:0] irq_flags = 8'h00;
  logic [7:0] irq_enables = 8'h00;
  logic wdt_enabled = 1'b0;
  logic wdt_from_sub_clk = 1'b0;
  logic wdt_overflow = 1'b0;
  logic ext_reset_req_n = 1'b1;
  logic [7:0] porta_pins = 8'hff;
  logic lvd_comparator_low = 1'b0;
  logic sys_clk_en, core_hold, state_retain, resume_after_halt, vector_irq, pending_irq;
  logic full_reset, wdt_reset, low_voltage_irq_flag, wdt_counter_clear, wdt_run, detector_on;
  logic [2:0] threshold_select;
  logic [31:0] mon_e, mon_m;
  logic [3:0] mon_ev;
  logic [31:0] rd_exp[$];
  logic [31:0] rd_msk[$];
  logic [3:0] ev_exp[$];
  int err_total = 0;
  int samples_checked = 0;
  int seed = 16042;

  always #10 pclk = ~pclk;

  pdw_power_down_wakeup_lvd #(.RESTART_CYC(RST_C), .LVD_DELAY_CYC(DLY_C))
  pdw_power_down_wakeup_lvd_i (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .halt_strobe(halt_strobe), .wdt_clear_strobe(wdt_clear_strobe),
    .stack_full(stack_full), .irq_flags(irq_flags), .irq_enables(irq_enables),
    .sys_clk_en(sys_clk_en), .core_hold(core_hold), .state_retain(state_retain),
    .resume_after_halt(resume_after_halt), .vector_irq(vector_irq),
    .pending_irq(pending_irq), .full_reset(full_reset), .wdt_reset(wdt_reset),
    .low_voltage_irq_flag(low_voltage_irq_flag), .wdt_enabled(wdt_enabled),
    .wdt_from_sub_clk(wdt_from_sub_clk), .wdt_overflow(wdt_overflow),
    .wdt_counter_clear(wdt_counter_clear), .wdt_run(wdt_run),
    .ext_reset_req_n(ext_reset_req_n), .porta_pins(porta_pins),
    .lvd_comparator_low(lvd_comparator_low), .detector_on(detector_on),
    .threshold_select(threshold_select)
  );

  pdw_core_model pdw_core_model_i (
    .pclk(pclk), .presetn(presetn), .sys_clk_en(sys_clk_en), .core_hold(core_hold),
    .halt_req(halt_req), .halt_strobe(halt_strobe)
  );

  task automatic wrap_up;
    if (err_total == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic timeout(input string what);
    err_total++;
    $display("MISMATCH at %0t: no answer in %s", $time, what);
    wrap_up();
  endtask : timeout

  // one apb transfer; holds the request until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
    begin
      n++;
      if (n > 50)
        timeout("apb");
      @(posedge pclk);
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1);
    rd_exp.push_back(e & m);
    rd_msk.push_back(m);
    apb(1'b0, a, 32'h0);
  endtask : rd

  task automatic wait_ev;
    int n;
    n = 0;
    while (ev_exp.size() != 0)
    begin
      n++;
      if (n > 300)
        timeout("wake");
      @(posedge pclk);
    end
  endtask : wait_ev

  task automatic halt;
    halt_req <= 1'b1;
    @(posedge pclk);
    halt_req <= 1'b0;
    repeat (3) @(posedge pclk);
    check(32'(core_hold), 32'h1);
    check(32'(sys_clk_en), 32'h0);
    check(32'(state_retain), 32'h1);
  endtask : halt

  // watcher: read data and wake pulses against the oldest notes
  always @(posedge pclk)
  begin
    if (presetn && psel && penable && !pwrite && pready)
    begin
      mon_e = rd_exp.pop_front();
      mon_m = rd_msk.pop_front();
      check(prdata & mon_m, mon_e);
      check(32'(pslverr), 32'h0);
    end
    if (presetn && {full_reset, wdt_reset, vector_irq, resume_after_halt} !== 4'h0)
    begin
      check(32'(sys_clk_en), 32'h1);
      mon_ev = (ev_exp.size() != 0) ? ev_exp.pop_front() : 4'h0;
      check(32'({full_reset, wdt_reset, vector_irq, resume_after_halt}), 32'(mon_ev));
    end
    if (presetn && halt_strobe && !core_hold)
      check(32'(wdt_counter_clear), 32'h1);
  end

  initial
  begin
    int i;
    int n;
    logic [31:0] d;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(ADDR_LVD_CTRL, {24'h0, LVD_CTRL_RESET});
    rd(ADDR_STATUS, 32'h0);
    wr(8'h14, 32'hffffffff);
    rd(8'h14, 32'h0);
    for (i = 0; i < 8; i++)
    begin
      d = $random(seed);
      d[2:0] = i[2:0];
      wr(ADDR_LVD_CTRL, d);
      rd(ADDR_LVD_CTRL, d & 32'h17);
      check(32'(threshold_select), 32'(i));
      check(32'(detector_on), 32'(d[4]));
    end
    // detector output, then the delayed flag
    wr(ADDR_LVD_CTRL, 32'h15);
    lvd_comparator_low <= 1'b1;
    n = 0;
    while (low_voltage_irq_flag !== 1'b1)
    begin
      n++;
      if (n > 200)
        timeout("detector");
      @(posedge pclk);
    end
    // two sync flops, the delay, the flag register and one edge to see it
    check(32'(n), 32'(DLY_C + 4));
    rd(ADDR_LVD_CTRL, 32'h35);
    wr(ADDR_LVD_CTRL, 32'h05);
    rd(ADDR_LVD_CTRL, 32'h05);
    lvd_comparator_low <= 1'b0;
    wr(ADDR_IRQ, 32'h1);
    rd(ADDR_IRQ, 32'h0, 32'h1);
    // port A: a disabled pin must not wake, an enabled one must
    wr(ADDR_WAKE_EN, 32'h01);
    halt();
    rd(ADDR_STATUS, 32'h5);
    rd(ADDR_LVD_CTRL, 32'h05);
    porta_pins <= 8'hfd;
    repeat (10) @(posedge pclk);
    check(32'(core_hold), 32'h1);
    // a frozen block must not see the enabled pin fall until clk_en returns
    clk_en <= 1'b0;
    porta_pins <= 8'hfc;
    repeat (10) @(posedge pclk);
    check(32'(core_hold), 32'h1);
    ev_exp.push_back(4'h1);
    clk_en <= 1'b1;
    wait_ev();
    rd(ADDR_WAKE_CAUSE, {29'h0, CAUSE_PORTA});
    rd(ADDR_STATUS, 32'h1);
    porta_pins <= 8'hff;
    // watchdog: clock source decides whether it runs asleep
    wdt_enabled <= 1'b1;
    wdt_from_sub_clk <= 1'b1;
    halt();
    check(32'(wdt_run), 32'h1);
    wdt_from_sub_clk <= 1'b0;
    @(posedge pclk);
    @(posedge pclk);
    check(32'(wdt_run), 32'h0);
    wdt_from_sub_clk <= 1'b1;
    wdt_overflow <= 1'b1;
    ev_exp.push_back(4'h4);
    @(posedge pclk);
    wdt_overflow <= 1'b0;
    wait_ev();
    rd(ADDR_STATUS, 32'h3);
    rd(ADDR_WAKE_CAUSE, {29'h0, CAUSE_WDT});
    wdt_clear_strobe <= 1'b1;
    @(posedge pclk);
    wdt_clear_strobe <= 1'b0;
    rd(ADDR_STATUS, 32'h0, 32'h1);
    // interrupts: disabled, stack full, then served by vectoring
    for (i = 0; i < 3; i++)
    begin
      irq_enables <= (i == 0) ? 8'h00 : 8'hff;
      stack_full <= (i == 1);
      halt();
      ev_exp.push_back((i == 2) ? 4'h2 : 4'h1);
      irq_flags[i] <= 1'b1;
      wait_ev();
      rd(ADDR_WAKE_CAUSE, {29'h0, CAUSE_IRQ});
      if (i < 2)
        check(32'(pending_irq), 32'h1);
    end
    // flags high at entry stay silent; external reset still wakes
    halt();
    repeat (20) @(posedge pclk);
    check(32'(core_hold), 32'h1);
    ev_exp.push_back(4'h8);
    ext_reset_req_n <= 1'b0;
    repeat (4) @(posedge pclk);
    ext_reset_req_n <= 1'b1;
    wait_ev();
    // enabled detector keeps watching in sleep; no request flag rose, so it resumes
    irq_flags <= 8'h00;
    wr(ADDR_LVD_CTRL, 32'h17);
    halt();
    ev_exp.push_back(4'h1);
    lvd_comparator_low <= 1'b1;
    wait_ev();
    rd(ADDR_WAKE_CAUSE, {29'h0, CAUSE_IRQ});
    check(32'(low_voltage_irq_flag), 32'h1);
    wrap_up();
  end
endmodule : tb
